// File: src/pwm_timer.sv
// 8-bit dual complementary pwm timer with avalon-mm register slave
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module pwm_timer
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic fast_peripheral_clock,
    output logic pwm_out_a,
    output logic pwm_out_a_inv,
    output logic pwm_out_b,
    output logic pwm_out_b_inv,
    output logic drive_a,
    output logic drive_a_inv,
    output logic drive_b,
    output logic drive_b_inv
);
    localparam int SYNC_W = 48;
    localparam int BACK_W = 11;

    // ****************************************
    // bus slave
    // ****************************************
    logic waitrequest_r, waitrequest_nxt;
    logic [31:0] readdata_r, readdata_nxt;
    logic commit;
    logic [7:0] wd, rd_byte;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic pwm_b_r, pwm_b_nxt;
    logic [1:0] mode_b_r, mode_b_nxt;
    logic [7:0] buf_a_r, buf_a_nxt, buf_b_r, buf_b_nxt;
    logic [7:0] top_r, top_nxt;
    logic [2:0] flags_r, flags_nxt;
    logic fast_en_r, fast_en_nxt;
    logic force_a_r, force_a_nxt, force_b_r, force_b_nxt;
    logic restart_r, restart_nxt;
    logic cnt_wr_r, cnt_wr_nxt;
    logic [7:0] cnt_wdata_r, cnt_wdata_nxt;
    logic [BACK_W-1:0] back_s1_r, back_s2_r;
    logic [7:0] cnt_rd;
    logic wrap_in, match_a_in, match_b_in;

    assign commit = !waitrequest_r && write && byteenable[0];
    assign wd = writedata[7:0];
    assign {cnt_rd, wrap_in, match_a_in, match_b_in} = back_s2_r;

    always_comb
    begin
        rd_byte = 8'h00;
        unique case (address)
            pwm_timer_pkg::CTRL_OFS: rd_byte = ctrl_r;
            pwm_timer_pkg::COUNT_OFS: rd_byte = cnt_rd;
            pwm_timer_pkg::CMP_A_OFS: rd_byte = buf_a_r;
            pwm_timer_pkg::CMP_B_OFS: rd_byte = buf_b_r;
            pwm_timer_pkg::TOP_OFS: rd_byte = top_r;
            pwm_timer_pkg::GEN_OFS: rd_byte = {1'b0, pwm_b_r, mode_b_r, 4'h0};
            pwm_timer_pkg::FLAG_OFS: rd_byte = {1'b0, flags_r[2], flags_r[1], 2'h0,
                                                flags_r[0], 2'h0};
            pwm_timer_pkg::PLL_OFS: rd_byte = {5'h00, fast_en_r, 2'h0};
            default: rd_byte = 8'h00;
        endcase
        // one wait cycle: request seen, answer on the next edge
        waitrequest_nxt = !(waitrequest_r && (read || write));
        readdata_nxt = (waitrequest_r && read) ? {24'h000000, rd_byte} : readdata_r;
    end

    // ****************************************
    // software registers and flags
    // ****************************************
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        pwm_b_nxt = pwm_b_r;
        mode_b_nxt = mode_b_r;
        buf_a_nxt = buf_a_r;
        buf_b_nxt = buf_b_r;
        top_nxt = top_r;
        fast_en_nxt = fast_en_r;
        force_a_nxt = 1'b0;
        force_b_nxt = 1'b0;
        restart_nxt = 1'b0;
        cnt_wr_nxt = 1'b0;
        cnt_wdata_nxt = cnt_wdata_r;
        flags_nxt = flags_r;
        if (commit)
        begin
            unique case (address)
                pwm_timer_pkg::CTRL_OFS: ctrl_nxt = wd;
                pwm_timer_pkg::COUNT_OFS:
                begin
                    cnt_wr_nxt = 1'b1;
                    cnt_wdata_nxt = wd;
                end
                pwm_timer_pkg::CMP_A_OFS: buf_a_nxt = wd;
                pwm_timer_pkg::CMP_B_OFS: buf_b_nxt = wd;
                pwm_timer_pkg::TOP_OFS: top_nxt = wd;
                pwm_timer_pkg::GEN_OFS:
                begin
                    pwm_b_nxt = wd[pwm_timer_pkg::GEN_PWM_B_BIT];
                    mode_b_nxt = wd[pwm_timer_pkg::GEN_MODE_LO +: 2];
                    force_a_nxt = wd[pwm_timer_pkg::GEN_FORCE_A_BIT];
                    force_b_nxt = wd[pwm_timer_pkg::GEN_FORCE_B_BIT];
                    restart_nxt = wd[pwm_timer_pkg::GEN_RESTART_BIT];
                end
                pwm_timer_pkg::FLAG_OFS:
                    flags_nxt = flags_r & ~{wd[pwm_timer_pkg::FLAG_MATCH_A_BIT],
                        wd[pwm_timer_pkg::FLAG_MATCH_B_BIT], wd[pwm_timer_pkg::FLAG_WRAP_BIT]};
                pwm_timer_pkg::PLL_OFS: fast_en_nxt = wd[pwm_timer_pkg::PLL_FAST_BIT];
                default: ctrl_nxt = ctrl_r;
            endcase
        end
        // a flag event in the clearing cycle survives the clear
        flags_nxt = flags_nxt | {match_a_in, match_b_in, wrap_in};
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            waitrequest_r <= 1'b1;
            readdata_r <= 32'h00000000;
            ctrl_r <= pwm_timer_pkg::CTRL_RST;
            pwm_b_r <= 1'b0;
            mode_b_r <= 2'b00;
            buf_a_r <= pwm_timer_pkg::CMP_RST;
            buf_b_r <= pwm_timer_pkg::CMP_RST;
            top_r <= pwm_timer_pkg::TOP_RST;
            flags_r <= 3'h0;
            fast_en_r <= 1'b0;
            force_a_r <= 1'b0;
            force_b_r <= 1'b0;
            restart_r <= 1'b0;
            cnt_wr_r <= 1'b0;
            cnt_wdata_r <= pwm_timer_pkg::COUNT_RST;
        end
        else
        begin
            waitrequest_r <= waitrequest_nxt;
            readdata_r <= readdata_nxt;
            ctrl_r <= ctrl_nxt;
            pwm_b_r <= pwm_b_nxt;
            mode_b_r <= mode_b_nxt;
            buf_a_r <= buf_a_nxt;
            buf_b_r <= buf_b_nxt;
            top_r <= top_nxt;
            flags_r <= flags_nxt;
            fast_en_r <= fast_en_nxt;
            force_a_r <= force_a_nxt;
            force_b_r <= force_b_nxt;
            restart_r <= restart_nxt;
            cnt_wr_r <= cnt_wr_nxt;
            cnt_wdata_r <= cnt_wdata_nxt;
        end
    end

    assign waitrequest = waitrequest_r;
    assign readdata = readdata_r;

    // ****************************************
    // two-stage settings pipeline and pin sampling
    // ****************************************
    logic [SYNC_W-1:0] sync_s1_r, sync_s2_r;
    logic [2:0] fpin_r;
    logic fast_lvl_r, fast_lvl_nxt;
    logic [7:0] ctrl_s, cmp_a_s, cmp_b_s, top_s, cnt_wdata_s;
    logic pwm_b_s, fast_en_s, force_a_s, force_b_s, restart_s, cnt_wr_s;
    logic [1:0] mode_b_s;
    logic [7:0] cnt_r, cnt_nxt, cnt_step, act_a_r, act_a_nxt, act_b_r, act_b_nxt;
    logic wrap_ev_r, wrap_ev_nxt, match_a_ev_r, match_b_ev_r;

    assign {ctrl_s, pwm_b_s, mode_b_s, cmp_a_s, cmp_b_s, top_s, fast_en_s, force_a_s,
            force_b_s, restart_s, cnt_wr_s, cnt_wdata_s} = sync_s2_r;

    always_comb
    begin
        // level only moves once the second and third samples agree
        fast_lvl_nxt = (fpin_r[1] == fpin_r[2]) ? fpin_r[2] : fast_lvl_r;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync_s1_r <= '0;
            sync_s2_r <= '0;
            back_s1_r <= '0;
            back_s2_r <= '0;
            fpin_r <= 3'h0;
            fast_lvl_r <= 1'b0;
        end
        else
        begin
            sync_s1_r <= {ctrl_r, pwm_b_r, mode_b_r, buf_a_r, buf_b_r, top_r, fast_en_r,
                          force_a_r, force_b_r, restart_r, cnt_wr_r, cnt_wdata_r};
            sync_s2_r <= sync_s1_r;
            back_s1_r <= {cnt_r, wrap_ev_r, match_a_ev_r, match_b_ev_r};
            back_s2_r <= back_s1_r;
            fpin_r <= {fpin_r[1:0], fast_peripheral_clock};
            fast_lvl_r <= fast_lvl_nxt;
        end
    end

    // ****************************************
    // prescaler and counter core
    // ****************************************
    logic [pwm_timer_pkg::PRESCALE_W-1:0] pre_r, pre_nxt, mask;
    logic [pwm_timer_pkg::PRESCALE_W:0] one_hot;
    logic base_tick, tick, adv, pwm_a_s, pwm_any, ctc_s, at_top, reload;
    logic match_a_ev, match_b_ev, zero_ev;
    logic [3:0] cs_s;

    assign pwm_a_s = ctrl_s[pwm_timer_pkg::CTRL_PWM_A_BIT];
    assign ctc_s = ctrl_s[pwm_timer_pkg::CTRL_CLEAR_BIT];
    assign cs_s = ctrl_s[pwm_timer_pkg::CTRL_CS_LO +: 4];

    always_comb
    begin
        // base clock: every system cycle, or each rising edge of the fast clock pin
        base_tick = fast_en_s ? (fast_lvl_nxt && !fast_lvl_r) : 1'b1;
        one_hot = 15'h0001 << (cs_s - 4'h1);
        mask = 14'(one_hot - 15'h0001);
        tick = (cs_s != pwm_timer_pkg::CS_STOP) && base_tick && ((pre_r & mask) == mask);
        pre_nxt = restart_s ? '0 : (base_tick ? 14'(pre_r + 14'h0001) : pre_r);
        pwm_any = pwm_a_s || pwm_b_s;
        at_top = (cnt_r == top_s);
        adv = tick && !cnt_wr_s;
        cnt_step = (at_top && (ctc_s || pwm_any)) ? pwm_timer_pkg::COUNT_RST
                                                    : 8'(cnt_r + 8'h01);
        reload = adv && at_top && pwm_any;
        cnt_nxt = cnt_wr_s ? cnt_wdata_s : (tick ? cnt_step : cnt_r);
        // pwm compares only move at top, so a period never sees a half-updated value
        act_a_nxt = (!pwm_a_s || reload) ? cmp_a_s : act_a_r;
        act_b_nxt = (!pwm_b_s || reload) ? cmp_b_s : act_b_r;
        wrap_ev_nxt = adv && (pwm_any ? at_top : (cnt_r == pwm_timer_pkg::COUNT_FULL));
        // only counting produces events, never a software write of the count
        match_a_ev = adv && (cnt_step == act_a_nxt);
        match_b_ev = adv && (cnt_step == act_b_nxt);
        zero_ev = adv && (cnt_step == pwm_timer_pkg::COUNT_RST);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pre_r <= '0;
            cnt_r <= pwm_timer_pkg::COUNT_RST;
            act_a_r <= pwm_timer_pkg::CMP_RST;
            act_b_r <= pwm_timer_pkg::CMP_RST;
            wrap_ev_r <= 1'b0;
            match_a_ev_r <= 1'b0;
            match_b_ev_r <= 1'b0;
        end
        else
        begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            act_a_r <= act_a_nxt;
            act_b_r <= act_b_nxt;
            wrap_ev_r <= wrap_ev_nxt;
            match_a_ev_r <= match_a_ev;
            match_b_ev_r <= match_b_ev;
        end
    end

    // ****************************************
    // output channels
    // ****************************************
    pwm_channel chan_a
    (
        .clk(clk),
        .rstn(rstn),
        .pwm_en(pwm_a_s),
        .mode(ctrl_s[pwm_timer_pkg::CTRL_MODE_LO +: 2]),
        .match_ev(match_a_ev),
        .zero_ev(zero_ev),
        .cmp_is_top(act_a_nxt == top_s),
        .force_ev(force_a_s),
        .out_true(pwm_out_a),
        .out_inv(pwm_out_a_inv),
        .drive_true(drive_a),
        .drive_inv(drive_a_inv)
    );

    pwm_channel chan_b
    (
        .clk(clk),
        .rstn(rstn),
        .pwm_en(pwm_b_s),
        .mode(mode_b_s),
        .match_ev(match_b_ev),
        .zero_ev(zero_ev),
        .cmp_is_top(act_b_nxt == top_s),
        .force_ev(force_b_s),
        .out_true(pwm_out_b),
        .out_inv(pwm_out_b_inv),
        .drive_true(drive_b),
        .drive_inv(drive_b_inv)
    );

    // ****************************************
    // checks
    // ****************************************
    pwm_top_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
        (adv && pwm_any && at_top) |=> (cnt_r == 8'h00))
        else $error("pwm counter did not restart after top");
    ctc_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        (adv && ctc_s && at_top) |=> (cnt_r == 8'h00))
        else $error("clear on top did not clear counter");
    no_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        (adv && !ctc_s && !pwm_any && at_top) |=> (cnt_r == 8'($past(cnt_r) + 8'h01)))
        else $error("counter cleared without clear on top");
    wrap_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        wrap_ev_r |-> ##3 flags_r[0])
        else $error("wrap flag not set three cycles after event");
    buffer_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (pwm_a_s && $past(pwm_a_s) && !$past(reload)) |-> $stable(act_a_r))
        else $error("active compare changed outside top");
    readback_a: assert property (@(posedge clk) disable iff (!rstn)
        (commit && address == 8'h38) |=> (buf_a_r == $past(writedata[7:0])))
        else $error("compare a readback not latest write");
    stop_a: assert property (@(posedge clk) disable iff (!rstn)
        (cs_s == 4'h0 && !cnt_wr_s) |=> $stable(cnt_r))
        else $error("counter moved while stopped");
    restart_a: assert property (@(posedge clk) disable iff (!rstn)
        restart_s |=> (pre_r == 14'h0000) && $stable(cnt_r) || $past(tick))
        else $error("prescaler restart failed");
    soft_write_a: assert property (@(posedge clk) disable iff (!rstn)
        cnt_wr_s |-> !(match_a_ev || match_b_ev || wrap_ev_nxt))
        else $error("software count write produced an event");
    bus_answer_a: assert property (@(posedge clk) disable iff (!rstn)
        (waitrequest_r && (read || write)) |=> !waitrequest_r ##1 waitrequest_r)
        else $error("bus answer not one cycle after request");
    wrap_cov: cover property (@(posedge clk) disable iff (!rstn) wrap_ev_r && pwm_any);
    match_cov: cover property (@(posedge clk) disable iff (!rstn) match_a_ev && pwm_a_s);
    cnt_write_cov: cover property (@(posedge clk) disable iff (!rstn) cnt_wr_s);

endmodule : pwm_timer

// File: src/pwm_timer_pkg.sv
// constants, register map and types shared by the dual complementary pwm timer
package pwm_timer_pkg;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [7:0] CTRL_OFS = 8'h30;
    localparam logic [7:0] COUNT_OFS = 8'h34;
    localparam logic [7:0] CMP_A_OFS = 8'h38;
    localparam logic [7:0] CMP_B_OFS = 8'h3C;
    localparam logic [7:0] TOP_OFS = 8'h40;
    localparam logic [7:0] GEN_OFS = 8'h44;
    localparam logic [7:0] FLAG_OFS = 8'h48;
    localparam logic [7:0] PLL_OFS = 8'h4C;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_CLEAR_BIT = 7;
    localparam int CTRL_PWM_A_BIT = 6;
    localparam int CTRL_MODE_LO = 4;
    localparam int CTRL_CS_LO = 0;
    localparam int GEN_PWM_B_BIT = 6;
    localparam int GEN_MODE_LO = 4;
    localparam int GEN_FORCE_B_BIT = 3;
    localparam int GEN_FORCE_A_BIT = 2;
    localparam int GEN_RESTART_BIT = 1;
    localparam int FLAG_MATCH_A_BIT = 6;
    localparam int FLAG_MATCH_B_BIT = 5;
    localparam int FLAG_WRAP_BIT = 2;
    localparam int PLL_FAST_BIT = 2;

    // ****************************************
    // reset values and fixed counts
    // ****************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [7:0] TOP_RST = 8'hFF;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] COUNT_FULL = 8'hFF;
    localparam logic [3:0] CS_STOP = 4'h0;
    localparam int PRESCALE_W = 14;

    // ****************************************
    // output compare modes
    // ****************************************
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_TOGGLE = 2'b01,
        MODE_CLEAR = 2'b10,
        MODE_SET = 2'b11
    } out_mode_t;

endpackage : pwm_timer_pkg

// File: src/pwm_channel.sv
// one compare output channel: true and complementary pin levels with drive enables
`timescale 1ns/1ps
module pwm_channel
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic pwm_en,
    input wire logic [1:0] mode,
    input wire logic match_ev,
    input wire logic zero_ev,
    input wire logic cmp_is_top,
    input wire logic force_ev,
    output logic out_true,
    output logic out_inv,
    output logic drive_true,
    output logic drive_inv
);
    logic lvl_r, lvl_nxt;
    logic inv_r, inv_nxt;
    logic drv_r, drv_nxt;
    logic drv_inv_r, drv_inv_nxt;
    logic eff_match;
    pwm_timer_pkg::out_mode_t m;

    // ****************************************
    // output level
    // ****************************************
    always_comb
    begin
        m = pwm_timer_pkg::out_mode_t'(mode);
        // a compare equal to top would give a one-tick glitch, so it holds the level
        eff_match = match_ev && !(pwm_en && cmp_is_top);
        lvl_nxt = lvl_r;
        if (pwm_en)
        begin
            unique case (m)
                pwm_timer_pkg::MODE_OFF: lvl_nxt = lvl_r;
                pwm_timer_pkg::MODE_TOGGLE, pwm_timer_pkg::MODE_CLEAR:
                begin
                    if (eff_match)
                        lvl_nxt = 1'b0;
                    else if (zero_ev)
                        lvl_nxt = 1'b1;
                end
                pwm_timer_pkg::MODE_SET:
                begin
                    if (eff_match)
                        lvl_nxt = 1'b1;
                    else if (zero_ev)
                        lvl_nxt = 1'b0;
                end
            endcase
        end
        else if (eff_match || force_ev)
        begin
            unique case (m)
                pwm_timer_pkg::MODE_OFF: lvl_nxt = lvl_r;
                pwm_timer_pkg::MODE_TOGGLE: lvl_nxt = !lvl_r;
                pwm_timer_pkg::MODE_CLEAR: lvl_nxt = 1'b0;
                pwm_timer_pkg::MODE_SET: lvl_nxt = 1'b1;
            endcase
        end
        // no dead time: the inverse switches on the same edge
        inv_nxt = !lvl_nxt;
        drv_nxt = (m != pwm_timer_pkg::MODE_OFF);
        drv_inv_nxt = pwm_en && (m == pwm_timer_pkg::MODE_TOGGLE);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lvl_r <= 1'b0;
            inv_r <= 1'b1;
            drv_r <= 1'b0;
            drv_inv_r <= 1'b0;
        end
        else
        begin
            lvl_r <= lvl_nxt;
            inv_r <= inv_nxt;
            drv_r <= drv_nxt;
            drv_inv_r <= drv_inv_nxt;
        end
    end

    assign out_true = lvl_r;
    assign out_inv = inv_r;
    assign drive_true = drv_r;
    assign drive_inv = drv_inv_r;

    // ****************************************
    // checks
    // ****************************************
    pwm_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        (pwm_en && mode == 2'b01 && match_ev && !cmp_is_top)
        |=> (!out_true && out_inv))
        else $error("pwm match did not clear true output");
    no_deadtime_a: assert property (@(posedge clk) disable iff (!rstn)
        (pwm_en && $stable(mode)) |-> (out_inv == !out_true))
        else $error("complementary output not inverse");
    normal_toggle_a: assert property (@(posedge clk) disable iff (!rstn)
        (!pwm_en && mode == 2'b01 && match_ev) |=> (out_true != $past(out_true)))
        else $error("normal mode match did not toggle");
    pwm_set_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        (pwm_en && mode == 2'b11 && zero_ev && !match_ev) |=> !out_true)
        else $error("mode 11 did not clear at zero");

endmodule : pwm_channel

// File: dv/pwm_load_model.sv
// load model: levels that the power stage sees on the four output pins
`timescale 1ns/1ps
module pwm_load_model
(
    input wire logic dir_set,
    input wire logic [3:0] level,
    input wire logic [3:0] drive,
    output logic [3:0] pin
);
    // an undriven pin falls to its pull-down instead of keeping the last level
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            pin[i] = (dir_set && drive[i]) ? level[i] : 1'b0;
    end
endmodule : pwm_load_model

// File: dv/pwm_timer_bench.sv
// self-checking bench for the dual complementary pwm timer
`timescale 1ns/1ps
module pwm_timer_bench;
    logic clk, rstn, read, write, fpck;
    logic [7:0] address;
    logic [31:0] writedata, readdata;
    logic waitrequest;
    logic [3:0] lvl, drv, pin;
    logic [7:0] q, q2;
    int bad_count, num_checks, hi;
    pwm_timer u_dut (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .fast_peripheral_clock(fpck), .pwm_out_a(lvl[0]),
        .pwm_out_a_inv(lvl[1]), .pwm_out_b(lvl[2]), .pwm_out_b_inv(lvl[3]), .drive_a(drv[0]),
        .drive_a_inv(drv[1]), .drive_b(drv[2]), .drive_b_inv(drv[3]));
    // port direction is tied set for the whole run, before any output mode is chosen
    pwm_load_model u_load (.dir_set(1'b1), .level(lvl), .drive(drv), .pin(pin));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // raised after a rising edge, held until waitrequest is sampled low at a rising edge;
    // an idle edge passes before the next raise so a strobe is never set twice in one step
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= {24'h000000, d};
        do
        begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata[7:0];
        chk("waitrequest", {7'h00, waitrequest}, 8'h00);
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    // counts high cycles of one channel pin; inverse checked only while it is driven
    task count_hi(input int n, input int ch);
        hi = 0;
        repeat (n)
        begin
            @(negedge clk);
            hi += pin[ch];
            if (drv[ch + 1] && pin[ch + 1] !== !pin[ch])
                chk("inverse", {7'h00, pin[ch + 1]}, {7'h00, !pin[ch]});
        end
    endtask : count_hi
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        bus(0, 8'h30, 8'h00);
        chk("control", q, 8'h00);
        bus(0, 8'h40, 8'h00);
        chk("top", q, 8'hFF);
        bus(0, 8'h50, 8'h00);
        chk("unmapped", q, 8'h00);
        chk("pins off", {4'h0, drv}, 8'h00);
    endtask : t_reset
    task t_pwm;
        bus(1, 8'h40, 8'h05);
        bus(1, 8'h38, 8'h02);
        bus(1, 8'h30, 8'h51);
        repeat (20) @(posedge clk);
        count_hi(12, 0);
        chk("duty", hi[7:0], 8'h04);
        chk("inv drive", {7'h00, drv[1]}, 8'h01);
        bus(1, 8'h38, 8'h00);
        bus(0, 8'h38, 8'h00);
        chk("cmp readback", q, 8'h00);
        repeat (20) @(posedge clk);
        count_hi(12, 0);
        chk("cmp zero", hi[7:0], 8'h00);
        bus(0, 8'h48, 8'h00);
        chk("wrap flag", q & 8'h04, 8'h04);
        bus(1, 8'h30, 8'h61);
        repeat (6) @(posedge clk);
        chk("mode10 inv", {7'h00, drv[1]}, 8'h00);
    endtask : t_pwm
    // channel b in mode 11 shares the counter: high from match to top
    task t_chan_b;
        bus(1, 8'h3C, 8'h02);
        bus(1, 8'h44, 8'h70);
        repeat (20) @(posedge clk);
        count_hi(12, 2);
        chk("duty b", hi[7:0], 8'h08);
        chk("b inv drive", {7'h00, drv[3]}, 8'h00);
    endtask : t_chan_b
    // normal mode with clear on top: toggle every top + 1 ticks, then a forced toggle
    task t_normal;
        bus(1, 8'h44, 8'h02);
        bus(1, 8'h30, 8'h91);
        repeat (20) @(posedge clk);
        count_hi(12, 0);
        chk("toggle", hi[7:0], 8'h06);
        chk("normal inv drive", {7'h00, drv[1]}, 8'h00);
        bus(1, 8'h30, 8'h90);
        repeat (6) @(posedge clk);
        q2 = {7'h00, pin[0]};
        bus(1, 8'h44, 8'h04);
        repeat (6) @(posedge clk);
        chk("force", {7'h00, pin[0]}, {7'h00, !q2[0]});
    endtask : t_normal
    // fast clock as base: no pin edge, no count; four rising edges, four counts
    task t_fast;
        bus(1, 8'h4C, 8'h04);
        bus(1, 8'h30, 8'h91);
        repeat (8) @(posedge clk);
        bus(0, 8'h34, 8'h00);
        q2 = q;
        bus(0, 8'h34, 8'h00);
        chk("no fast edge", q, q2);
        repeat (4)
        begin
            fpck <= 1'b1;
            repeat (4) @(posedge clk);
            fpck <= 1'b0;
            repeat (4) @(posedge clk);
        end
        bus(0, 8'h34, 8'h00);
        chk("fast ticks", q, 8'((q2 + 8'h04) % 8'h06));
        bus(1, 8'h4C, 8'h00);
    endtask : t_fast
    task t_stop;
        bus(1, 8'h30, 8'h50);
        repeat (6) @(posedge clk);
        bus(0, 8'h34, 8'h00);
        q2 = q;
        repeat (10) @(posedge clk);
        bus(0, 8'h34, 8'h00);
        chk("stopped", q, q2);
    endtask : t_stop
    initial
    begin
        rstn = 1'b0;
        read = 1'b0;
        write = 1'b0;
        fpck = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        bad_count = 0;
        num_checks = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset;
        t_pwm;
        t_chan_b;
        t_normal;
        t_fast;
        t_stop;
        // reset again in mid-run: control and top must come back to their reset values, all drives off
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset;
        conclude;
    end
    initial
    begin
        #40000;
        bad_count++;
        conclude;
    end
endmodule : pwm_timer_bench
